// ### hdl/pmd_pkg.sv
// Purpose: Shared constants and types for the peripheral module disable block
// Assumes: 32-bit AXI4-Lite register access, 8-bit peripheral register bus
// Notes:   Slot order maps each gated peripheral to its disable bit
`default_nettype none
package pmd_pkg;
  // Register map (byte addresses)
  localparam int          AXI_ADDR_W      = 12;
  localparam logic [11:0] MOD_DIS0_ADDR   = 12'h10C;
  localparam logic [11:0] SLOT_STAT_ADDR  = 12'h110;

  // Fields of module_disable_0
  localparam int          TIMER_ZERO_BIT  = 7;
  localparam int          PIN_CHANGE_BIT  = 5;
  localparam int          CLOCK_NET_BIT   = 3;
  localparam int          MEM_SCAN_BIT    = 2;
  localparam int          CHECKSUM_BIT    = 1;
  localparam int          NV_ACCESS_BIT   = 0;
  localparam logic [7:0]  MOD_DIS0_RESET  = 8'h00;
  localparam logic [7:0]  MOD_DIS0_MASK   = 8'hAF;

  // Gated peripheral slots and the disable bit that owns each
  localparam int          NUM_SLOTS       = 6;
  localparam int          SLOT_BIT [NUM_SLOTS] = '{0, 1, 2, 3, 5, 7};

  // Timing
  localparam int          CORE_CLK_PERIOD_PS  = 8000;
  localparam int          INSTR_CYCLE_PS      = 32000;
  localparam int          INSTR_CYCLE_CLKS    = INSTR_CYCLE_PS / CORE_CLK_PERIOD_PS;
  localparam logic [1:0]  RATE_DIV_LAST       = 2'(INSTR_CYCLE_CLKS - 1);
  localparam logic [1:0]  SETTLE_INSTR_CYCLES = 2'h2;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [2:0] slot;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pmd_sfr_req_t;

  typedef logic [NUM_SLOTS-1:0][7:0] pmd_slot_bytes_t;
endpackage : pmd_pkg
`default_nettype wire

// ### hdl/pmd_rate_div.sv
// Purpose: Full-rate and quarter-rate peripheral clock enables
// Assumes: One core clock; slower rates are one-cycle enables
// Notes:   Quarter-rate enable never stops, full-rate follows the net bit
`timescale 1ns/1ps
`default_nettype none
module pmd_rate_div (
  input  wire logic clk_in,         // Core clock
  input  wire logic rst_b_in,       // Async reset, active low
  input  wire logic net_off_in,     // Clock network disable
  output var  logic full_en_out,    // Full-rate enable
  output var  logic quarter_en_out  // Quarter-rate enable pulse
);
  import pmd_pkg::*;

  logic [1:0] div_reg;
  logic [1:0] div_next;
  logic       wrap;

  assign wrap     = (div_reg == RATE_DIV_LAST);
  assign div_next = wrap ? 2'h0 : 2'(div_reg + 2'h1);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_reg        <= 2'h0;
      full_en_out    <= 1'b0;
      quarter_en_out <= 1'b0;
    end else begin
      div_reg        <= div_next;
      full_en_out    <= !net_off_in;
      quarter_en_out <= wrap;
    end
  end

  a_quarter_period: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    quarter_en_out |=> !quarter_en_out [*3] ##1 quarter_en_out)
    else $error("quarter-rate enable period wrong");

  a_full_rate_off: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    net_off_in |=> !full_en_out)
    else $error("full-rate enable ran while network disabled");
endmodule : pmd_rate_div
`default_nettype wire

// ### hdl/pmd_slot.sv
// Purpose: Hold one peripheral in reset and fence its registers and outputs
// Assumes: Register requests and peripheral outputs are on the core clock
// Notes:   Read data is combinational; the top registers it
`timescale 1ns/1ps
`default_nettype none
module pmd_slot (
  input  wire logic       clk_in,         // Core clock
  input  wire logic       rst_b_in,       // Async reset, active low
  input  wire logic       off_in,         // Disable bit for this peripheral
  input  wire logic       hit_in,         // Request targets this peripheral
  input  wire logic       wr_in,          // Register write request
  input  wire logic       rd_in,          // Register read request
  input  wire logic       quarter_en_in,  // Instruction-cycle enable
  input  wire logic [7:0] rdata_in,       // Peripheral read data
  input  wire logic [7:0] outs_in,        // Peripheral raw outputs
  output var  logic [7:0] rdata_out,      // Fenced read data
  output var  logic       wr_en_out,      // Fenced write enable
  output var  logic       rst_b_out,      // Peripheral reset, active low
  output var  logic [7:0] outs_out,       // Fenced outputs
  output var  logic       settled_out     // Safe to access after re-enable
);
  import pmd_pkg::*;

  logic [1:0] settle_reg;
  logic       settle_step;

  assign rdata_out   = (hit_in && rd_in && !off_in) ? rdata_in : 8'h00;
  assign settle_step = quarter_en_in && !settled_out;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_en_out   <= 1'b0;
      rst_b_out   <= 1'b0;
      outs_out    <= 8'h00;
      settle_reg  <= 2'h0;
      settled_out <= 1'b0;
    end else begin
      rst_b_out <= !off_in;
      wr_en_out <= hit_in && wr_in && !off_in;
      outs_out  <= off_in ? 8'h00 : outs_in;
      if (off_in) begin
        settle_reg  <= 2'h0;
        settled_out <= 1'b0;
      end else if (settle_step) begin
        settle_reg  <= 2'(settle_reg + 2'h1);
        settled_out <= (2'(settle_reg + 2'h1) == SETTLE_INSTR_CYCLES);
      end
    end
  end

  a_held_reset: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    off_in |=> !rst_b_out)
    else $error("disabled peripheral left out of reset");

  a_outs_forced: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    off_in |=> (outs_out == 8'h00))
    else $error("disabled peripheral output leaked");

  a_write_fenced: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (off_in || !hit_in) |=> !wr_en_out)
    else $error("write reached a disabled peripheral");

  a_reenable_release: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $fell(off_in) |=> rst_b_out && !settled_out)
    else $error("re-enabled peripheral not released from reset");
endmodule : pmd_slot
`default_nettype wire

// ### hdl/pmd_top.sv
// Purpose: Peripheral module disable register and fencing of six peripherals
// Assumes: AXI4-Lite register access, peripheral register bus on core clock
// Notes:   Peripherals come back from reset with power-on register values
//
// What this block does
// - Any reset clears all disable bits
// - Set bit holds peripheral in reset
// - Disabled registers ignore writes, read zero
// - Disabled peripheral outputs forced off
// - Clearing bit releases peripheral with reset values
// - Disable bits 7,5,3,2,1,0 at 0x010C
// - Clock bit stops full rate, quarter runs
// - Memory-access bit blocks nonvolatile reads, writes
// - Scanner and checksum bits disable those units
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pmd_top (
  input  wire logic                   CORE_CLK_IN,          // Core clock, 125 MHz
  input  wire logic                   RST_B_IN,             // Async reset, active low
  // AXI4-Lite slave
  input  wire logic                   AXI_AWVALID_IN,       // Write address valid
  output var  logic                   AXI_AWREADY_OUT,      // Write address ready
  input  wire logic [11:0]            AXI_AWADDR_IN,        // Write address
  input  wire logic                   AXI_WVALID_IN,        // Write data valid
  output var  logic                   AXI_WREADY_OUT,       // Write data ready
  input  wire logic [31:0]            AXI_WDATA_IN,         // Write data
  input  wire logic [3:0]             AXI_WSTRB_IN,         // Write strobes
  output var  logic                   AXI_BVALID_OUT,       // Write response valid
  input  wire logic                   AXI_BREADY_IN,        // Write response ready
  output var  logic [1:0]             AXI_BRESP_OUT,        // Write response
  input  wire logic                   AXI_ARVALID_IN,       // Read address valid
  output var  logic                   AXI_ARREADY_OUT,      // Read address ready
  input  wire logic [11:0]            AXI_ARADDR_IN,        // Read address
  output var  logic                   AXI_RVALID_OUT,       // Read data valid
  input  wire logic                   AXI_RREADY_IN,        // Read data ready
  output var  logic [31:0]            AXI_RDATA_OUT,        // Read data
  output var  logic [1:0]             AXI_RRESP_OUT,        // Read response
  // Core side of the peripheral register bus
  input  wire pmd_pkg::pmd_sfr_req_t  SFR_REQ_IN,           // Peripheral register request
  output var  logic [7:0]             SFR_RDATA_OUT,        // Fenced read data
  // Peripheral side
  input  wire pmd_pkg::pmd_slot_bytes_t PERIPH_RDATA_IN,    // Per-slot read data
  input  wire pmd_pkg::pmd_slot_bytes_t PERIPH_OUTS_IN,     // Per-slot raw outputs
  output var  logic [7:0]             PERIPH_ADDR_OUT,      // Register address
  output var  logic [7:0]             PERIPH_WDATA_OUT,     // Register write data
  output var  logic [5:0]             PERIPH_WR_EN_OUT,     // Per-slot write enable
  output var  logic [5:0]             PERIPH_RST_B_OUT,     // Per-slot reset, active low
  output var  pmd_pkg::pmd_slot_bytes_t PERIPH_OUTS_OUT,    // Per-slot fenced outputs
  output var  logic                   FULL_RATE_EN_OUT,     // Full-rate clock enable
  output var  logic                   QUARTER_RATE_EN_OUT,  // Quarter-rate enable pulse
  // Nonvolatile memory requests
  input  wire logic                   NVM_RD_REQ_IN,        // Memory read request
  input  wire logic                   NVM_WR_REQ_IN,        // Memory write request
  output var  logic                   NVM_RD_REQ_OUT,       // Gated memory read
  output var  logic                   NVM_WR_REQ_OUT,       // Gated memory write
  output var  logic [7:0]             MODULE_DISABLE_OUT    // Current disable bits
);
  import pmd_pkg::*;

  // Register and AXI state
  logic [7:0]  mod_dis_reg;
  logic [7:0]  mod_dis_next;
  logic        aw_got_reg;
  logic        w_got_reg;
  logic [11:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        first_cyc_reg;

  // Write channel decode
  logic        aw_take;
  logic        w_take;
  logic        have_aw;
  logic        have_w;
  logic        do_write;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_hit_dis;
  logic        wr_hit_stat;
  logic        aw_got_next;
  logic        w_got_next;
  logic        bvalid_next;
  logic [1:0]  bresp_next;

  // Read channel decode
  logic        ar_take;
  logic        rvalid_next;
  logic        rd_hit_dis;
  logic        rd_hit_stat;
  logic [31:0] rd_word;
  logic [1:0]  rd_resp;

  // Slot wiring
  logic [5:0]        slot_off;
  logic [5:0]        slot_hit;
  logic [5:0]        slot_wr_en;
  logic [5:0]        slot_rst_b;
  logic [5:0]        slot_settled;
  pmd_slot_bytes_t   slot_rdata;
  pmd_slot_bytes_t   slot_outs;
  logic [7:0]        sfr_rdata_any;
  logic              full_en;
  logic              quarter_en;

  // Write path: address and data may arrive in either order
  assign aw_take     = AXI_AWVALID_IN && AXI_AWREADY_OUT;
  assign w_take      = AXI_WVALID_IN && AXI_WREADY_OUT;
  assign have_aw     = aw_got_reg || aw_take;
  assign have_w      = w_got_reg || w_take;
  assign do_write    = have_aw && have_w;
  assign wr_addr     = aw_got_reg ? aw_addr_reg : AXI_AWADDR_IN;
  assign wr_data     = w_got_reg ? w_data_reg : AXI_WDATA_IN;
  assign wr_strb     = w_got_reg ? w_strb_reg : AXI_WSTRB_IN;
  assign aw_got_next = have_aw && !do_write;
  assign w_got_next  = have_w && !do_write;
  assign bvalid_next = do_write || (AXI_BVALID_OUT && !AXI_BREADY_IN);

  // Address decoding
  assign wr_hit_dis  = (wr_addr[11:2] == MOD_DIS0_ADDR[11:2]);
  assign wr_hit_stat = (wr_addr[11:2] == SLOT_STAT_ADDR[11:2]);
  assign rd_hit_dis  = (AXI_ARADDR_IN[11:2] == MOD_DIS0_ADDR[11:2]);
  assign rd_hit_stat = (AXI_ARADDR_IN[11:2] == SLOT_STAT_ADDR[11:2]);

  // Status register is read-only; a write to it is accepted and dropped
  assign bresp_next = (wr_hit_dis || wr_hit_stat) ? RESP_OKAY : RESP_SLVERR;

  assign mod_dis_next = (do_write && wr_hit_dis && wr_strb[0])
                        ? (wr_data[7:0] & MOD_DIS0_MASK) : mod_dis_reg;

  // Read path
  assign ar_take     = AXI_ARVALID_IN && AXI_ARREADY_OUT;
  assign rvalid_next = ar_take || (AXI_RVALID_OUT && !AXI_RREADY_IN);
  assign rd_word     = rd_hit_dis  ? {24'h000000, mod_dis_reg}
                     : rd_hit_stat ? {26'h0000000, slot_settled}
                     : 32'h00000000;
  assign rd_resp     = (rd_hit_dis || rd_hit_stat) ? RESP_OKAY : RESP_SLVERR;

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      mod_dis_reg <= MOD_DIS0_RESET;
      first_cyc_reg <= 1'b1;
    end else begin
      mod_dis_reg <= mod_dis_next;
      first_cyc_reg <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      aw_got_reg      <= 1'b0;
      w_got_reg       <= 1'b0;
      aw_addr_reg     <= 12'h000;
      w_data_reg      <= 32'h00000000;
      w_strb_reg      <= 4'h0;
      AXI_AWREADY_OUT <= 1'b0;
      AXI_WREADY_OUT  <= 1'b0;
      AXI_BVALID_OUT  <= 1'b0;
      AXI_BRESP_OUT   <= 2'h0;
    end else begin
      aw_got_reg      <= aw_got_next;
      w_got_reg       <= w_got_next;
      if (aw_take) begin
        aw_addr_reg <= AXI_AWADDR_IN;
      end
      if (w_take) begin
        w_data_reg <= AXI_WDATA_IN;
        w_strb_reg <= AXI_WSTRB_IN;
      end
      AXI_AWREADY_OUT <= !aw_got_next && !bvalid_next;
      AXI_WREADY_OUT  <= !w_got_next && !bvalid_next;
      AXI_BVALID_OUT  <= bvalid_next;
      if (do_write) begin
        AXI_BRESP_OUT <= bresp_next;
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      AXI_ARREADY_OUT <= 1'b0;
      AXI_RVALID_OUT  <= 1'b0;
      AXI_RDATA_OUT   <= 32'h00000000;
      AXI_RRESP_OUT   <= 2'h0;
    end else begin
      AXI_ARREADY_OUT <= !rvalid_next;
      AXI_RVALID_OUT  <= rvalid_next;
      if (ar_take) begin
        AXI_RDATA_OUT <= rd_word;
        AXI_RRESP_OUT <= rd_resp;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_SLOTS; g = g + 1) begin : g_slot
      assign slot_off[g] = mod_dis_reg[SLOT_BIT[g]];
      assign slot_hit[g] = (SFR_REQ_IN.slot == 3'(g));
      pmd_slot u_slot (
        .clk_in        (CORE_CLK_IN),
        .rst_b_in      (RST_B_IN),
        .off_in        (slot_off[g]),
        .hit_in        (slot_hit[g]),
        .wr_in         (SFR_REQ_IN.wr),
        .rd_in         (SFR_REQ_IN.rd),
        .quarter_en_in (quarter_en),
        .rdata_in      (PERIPH_RDATA_IN[g]),
        .outs_in       (PERIPH_OUTS_IN[g]),
        .rdata_out     (slot_rdata[g]),
        .wr_en_out     (slot_wr_en[g]),
        .rst_b_out     (slot_rst_b[g]),
        .outs_out      (slot_outs[g]),
        .settled_out   (slot_settled[g])
      );
    end
  endgenerate

  // Only one slot can hit, so an OR picks its data
  assign sfr_rdata_any = slot_rdata[0] | slot_rdata[1] | slot_rdata[2]
                       | slot_rdata[3] | slot_rdata[4] | slot_rdata[5];

  assign PERIPH_WR_EN_OUT = slot_wr_en;
  assign PERIPH_RST_B_OUT = slot_rst_b;
  assign PERIPH_OUTS_OUT  = slot_outs;

  pmd_rate_div u_rate_div (
    .clk_in         (CORE_CLK_IN),
    .rst_b_in       (RST_B_IN),
    .net_off_in     (mod_dis_reg[CLOCK_NET_BIT]),
    .full_en_out    (full_en),
    .quarter_en_out (quarter_en)
  );

  assign FULL_RATE_EN_OUT    = full_en;
  assign QUARTER_RATE_EN_OUT = quarter_en;

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      SFR_RDATA_OUT      <= 8'h00;
      PERIPH_ADDR_OUT    <= 8'h00;
      PERIPH_WDATA_OUT   <= 8'h00;
      NVM_RD_REQ_OUT     <= 1'b0;
      NVM_WR_REQ_OUT     <= 1'b0;
      MODULE_DISABLE_OUT <= 8'h00;
    end else begin
      SFR_RDATA_OUT      <= sfr_rdata_any;
      PERIPH_ADDR_OUT    <= SFR_REQ_IN.addr;
      PERIPH_WDATA_OUT   <= SFR_REQ_IN.wdata;
      NVM_RD_REQ_OUT     <= NVM_RD_REQ_IN && !mod_dis_reg[NV_ACCESS_BIT];
      NVM_WR_REQ_OUT     <= NVM_WR_REQ_IN && !mod_dis_reg[NV_ACCESS_BIT];
      MODULE_DISABLE_OUT <= mod_dis_reg;
    end
  end

  a_reset_clear: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    first_cyc_reg |-> (mod_dis_reg == 8'h00) && (PERIPH_RST_B_OUT == 6'h00))
    else $error("disable bits not clear after reset");

  a_unimpl_bits: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    AXI_RVALID_OUT && $past(ar_take) && $past(rd_hit_dis) |-> AXI_RDATA_OUT[6] == 1'b0
      && AXI_RDATA_OUT[4] == 1'b0)
    else $error("unimplemented disable bits read nonzero");

  a_map_write: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    do_write && wr_hit_dis && wr_strb[0] |=> mod_dis_reg == ($past(wr_data[7:0]) & 8'hAF)
      ##1 MODULE_DISABLE_OUT == $past(mod_dis_reg))
    else $error("disable register write mapped wrongly");

  a_read_zero: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    SFR_REQ_IN.rd && SFR_REQ_IN.slot == 3'h1 && mod_dis_reg[1] |=> SFR_RDATA_OUT == 8'h00)
    else $error("disabled checksum unit returned read data");

  a_scan_reset: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    mod_dis_reg[2] |=> !PERIPH_RST_B_OUT[2] && PERIPH_OUTS_OUT[2] == 8'h00)
    else $error("disabled scanner still running");

  a_nvm_blocked: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    mod_dis_reg[0] |=> !NVM_RD_REQ_OUT && !NVM_WR_REQ_OUT && !PERIPH_WR_EN_OUT[0])
    else $error("memory access passed while disabled");

  a_clock_net: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    mod_dis_reg[3] |=> !FULL_RATE_EN_OUT ##[0:3] QUARTER_RATE_EN_OUT)
    else $error("full-rate enable ran with network disabled");

  a_reenable_wait: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    $fell(mod_dis_reg[1]) |=> !slot_settled[1] [*4])
    else $error("re-enabled slot reported settled too early");

  a_reenable_back: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    $fell(mod_dis_reg[5]) |=> ##1 PERIPH_RST_B_OUT[4])
    else $error("re-enabled pin-change unit held in reset");
endmodule : pmd_top
`default_nettype wire

// ### tb/pmd_periph_model.sv
// Purpose: Six gated peripherals, one register each, seen by the fence
// Assumes: Register writes arrive as one-cycle enables on the core clock
// Notes:   Held in reset the model shows its power-on value, not zero
`timescale 1ns/1ps
`default_nettype none
module pmd_periph_model
  import pmd_pkg::*;
#(
  parameter logic [7:0] POR_BASE = 8'h50  // Power-on value of slot 0
) (
  input  wire logic            clk_in,     // Core clock
  input  wire logic [5:0]      rst_b_in,   // Per-slot reset, active low
  input  wire logic [5:0]      wr_en_in,   // Per-slot write enable
  input  wire logic [7:0]      wdata_in,   // Register write data
  output var  pmd_slot_bytes_t rdata_out,  // Per-slot read data
  output var  pmd_slot_bytes_t outs_out    // Per-slot raw outputs
);
  logic [7:0] regs [NUM_SLOTS];

  for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot
    // Distinct power-on values expose a swapped slot
    always_ff @(posedge clk_in or negedge rst_b_in[g]) begin
      if (!rst_b_in[g]) begin
        regs[g] <= POR_BASE + 8'(g);
      end else if (wr_en_in[g]) begin
        regs[g] <= wdata_in;
      end
    end
    assign rdata_out[g] = regs[g];
    assign outs_out[g]  = ~regs[g];
  end
endmodule : pmd_periph_model
`default_nettype wire

// ### tb/tb.sv
// Purpose: Register, fence and gating tests for the module disable block
// Assumes: AXI4-Lite master and peripheral register bus driven here
// Notes:   Peripheral side is the behavioural model
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pmd_pkg::*;
  localparam logic [7:0] POR_B = 8'h50;
  logic            clk = 1'b0;
  logic            rst_b = 1'b0;
  logic            awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic            nrd = 1'b0, nwr = 1'b0;
  logic [11:0]     awa = 12'h000, ara = 12'h000;
  logic [31:0]     wd = 32'h0;
  pmd_sfr_req_t    sreq = '0;
  logic            awr, wr, bv, arr, rv, fr, qr, nrd_o, nwr_o;
  logic [1:0]      bresp, rresp, r;
  logic [31:0]     rdat, d;
  logic [7:0]      srd, paddr, pwd, mdo, d8;
  logic [5:0]      pwe, prst;
  pmd_slot_bytes_t prd, pouts, pfo;
  int              error_cnt = 0;
  int              tests_run = 0;
  int              q;

  always #4 clk = ~clk;

  pmd_top uut (.CORE_CLK_IN(clk), .RST_B_IN(rst_b), .AXI_AWVALID_IN(awv),
    .AXI_AWREADY_OUT(awr), .AXI_AWADDR_IN(awa), .AXI_WVALID_IN(wv), .AXI_WREADY_OUT(wr),
    .AXI_WDATA_IN(wd), .AXI_WSTRB_IN(4'hF), .AXI_BVALID_OUT(bv), .AXI_BREADY_IN(br),
    .AXI_BRESP_OUT(bresp), .AXI_ARVALID_IN(arv), .AXI_ARREADY_OUT(arr),
    .AXI_ARADDR_IN(ara), .AXI_RVALID_OUT(rv), .AXI_RREADY_IN(rr), .AXI_RDATA_OUT(rdat),
    .AXI_RRESP_OUT(rresp), .SFR_REQ_IN(sreq), .SFR_RDATA_OUT(srd), .PERIPH_RDATA_IN(prd),
    .PERIPH_OUTS_IN(pouts), .PERIPH_ADDR_OUT(paddr), .PERIPH_WDATA_OUT(pwd),
    .PERIPH_WR_EN_OUT(pwe), .PERIPH_RST_B_OUT(prst), .PERIPH_OUTS_OUT(pfo),
    .FULL_RATE_EN_OUT(fr), .QUARTER_RATE_EN_OUT(qr), .NVM_RD_REQ_IN(nrd),
    .NVM_WR_REQ_IN(nwr), .NVM_RD_REQ_OUT(nrd_o), .NVM_WR_REQ_OUT(nwr_o),
    .MODULE_DISABLE_OUT(mdo));

  pmd_periph_model #(.POR_BASE(POR_B)) peer (.clk_in(clk), .rst_b_in(prst),
    .wr_en_in(pwe), .wdata_in(pwd), .rdata_out(prd), .outs_out(pouts));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] o);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= v;
    br <= 1'b1;
    // Either channel may be taken first
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (!aw_ok && awr === 1'b1) begin
        aw_ok = 1'b1;
        awv <= 1'b0;
      end
      if (!w_ok && wr === 1'b1) begin
        w_ok = 1'b1;
        wv <= 1'b0;
      end
    end
    while (bv !== 1'b1) @(posedge clk);
    o = bresp;
    br <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] o);
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rr <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    v = rdat;
    o = rresp;
    rr <= 1'b0;
  endtask : axi_rd

  // One-cycle request; answers are sampled once the next edge has landed
  task automatic sfr(input logic w, input int s, input logic [7:0] v, output logic [7:0] o);
    @(posedge clk);
    sreq <= '{rd: !w, wr: w, slot: 3'(s), addr: 8'h20 + 8'(s), wdata: v};
    @(posedge clk);
    sreq <= '0;
    #1 o = srd;
  endtask : sfr

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    end_of_test;
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    axi_rd(MOD_DIS0_ADDR, d, r);
    chk(d, 32'h0);
    chk(r, RESP_OKAY);
    chk(prst, 6'h3F);
    for (int s = 0; s < NUM_SLOTS; s++) begin
      sfr(1'b1, s, 8'hC0 + 8'(s), d8);
      chk(pwe, 6'h1 << s);
      chk(paddr, 8'h20 + 8'(s));
      chk(pwd, 8'hC0 + 8'(s));
      sfr(1'b0, s, 8'h00, d8);
      chk(d8, 8'hC0 + 8'(s));
    end
    // A slot number with no peripheral behind it
    sfr(1'b1, 6, 8'h5A, d8);
    chk(pwe, 6'h00);
    sfr(1'b0, 6, 8'h00, d8);
    chk(d8, 8'h00);
    axi_wr(MOD_DIS0_ADDR, 32'hFF, r);
    chk(r, RESP_OKAY);
    axi_rd(MOD_DIS0_ADDR, d, r);
    chk(d, 32'hAF);
    #1 chk(mdo, 8'hAF);
    chk(prst, 6'h00);
    chk(pfo, '0);
    chk(fr, 1'b0);
    q = 0;
    @(posedge clk);
    nrd <= 1'b1;
    nwr <= 1'b1;
    repeat (8) begin
      @(posedge clk);
      #1 q += int'(qr === 1'b1);
    end
    chk(q, 2);
    chk({nrd_o, nwr_o}, 2'b00);
    for (int s = 0; s < NUM_SLOTS; s++) begin
      sfr(1'b1, s, 8'h33, d8);
      chk(pwe, 6'h00);
      sfr(1'b0, s, 8'h00, d8);
      chk(d8, 8'h00);
    end
    axi_wr(MOD_DIS0_ADDR, 32'h0, r);
    // Software side waits for the settled flags before touching slots
    q = 0;
    do begin
      axi_rd(SLOT_STAT_ADDR, d, r);
      q++;
    end while (d !== 32'h3F && q < 20);
    chk(d, 32'h3F);
    chk({nrd_o, nwr_o}, 2'b11);
    for (int s = 0; s < NUM_SLOTS; s++) begin
      sfr(1'b0, s, 8'h00, d8);
      chk(d8, POR_B + 8'(s));
      chk(pfo[s], 8'(~(POR_B + 8'(s))));
    end
    for (int s = 0; s < NUM_SLOTS; s++) begin
      axi_wr(MOD_DIS0_ADDR, 32'h1 << SLOT_BIT[s], r);
      repeat (2) @(posedge clk);
      #1 chk(prst, 6'(~(6'h1 << s)));
      chk(fr, s != 3);
      chk({nrd_o, nwr_o}, {2{s != 0}});
    end
    axi_wr(12'h200, 32'h1, r);
    chk(r, RESP_SLVERR);
    axi_rd(12'h200, d, r);
    chk(r, RESP_SLVERR);
    axi_wr(SLOT_STAT_ADDR, 32'h0, r);
    chk(r, RESP_OKAY);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    axi_rd(MOD_DIS0_ADDR, d, r);
    chk(d, 32'h0);
    chk(prst, 6'h3F);
    end_of_test;
  end
endmodule : tb
`default_nettype wire
